// [rtl/rtw_consts.svh]
`ifndef RTW_CONSTS_SVH
`define RTW_CONSTS_SVH

// Serial byte shape
`define RTW_BYTE_W 8
`define RTW_LAST_BIT 3'h7
`define RTW_ADDR_W 4
`define RTW_NUM_ADDR 16
`define RTW_ADDR_MSB 7
`define RTW_ADDR_LSB 4
`define RTW_FMT_MSB 3
`define RTW_FMT_LSB 0
`define RTW_ADDR_STEP 4'h1
`define RTW_BIT_STEP 3'h1

// Pins that cross into the system clock domain
`define RTW_SYNC_N 3

// Transfer-format codes
`define RTW_FMT_WR_ONE 4'h8
`define RTW_FMT_WR_BURST 4'h0
`define RTW_FMT_RD_ONE 4'hc
`define RTW_FMT_RD_BURST 4'h4

// Reset values
`define RTW_RST_ADDR 4'h0
`define RTW_RST_FMT 4'h0
`define RTW_RST_BYTE 8'h00
`define RTW_RST_CNT 3'h0

`endif

// [rtl/rtw_pkg.sv]
package rtw_pkg;

   // Gray-coded along command -> write / command -> read
   typedef enum logic [1:0]
   {
      RTW_ST_CMD = 2'h0,
      RTW_ST_WR = 2'h1,
      RTW_ST_RD = 2'h2
   } rtw_state_type;

endpackage : rtw_pkg

// [rtl/rtw_port.sv]
`timescale 1ns/100ps
`include "rtw_consts.svh"

// How it works
// - Chip enable high frames a transfer; bytes are eight bits, MSB first.
// - First byte: upper nibble loads address pointer, lower nibble loads format.
// - Clock level at chip-enable rise picks drive and sample edges.
// - Format 8h writes one byte, then a new command byte may follow.
// - Format 0h burst write stores each byte, address increments wrapping Fh to 0h.
// - Burst write runs until chip enable falls.
// - Format Ch reads one byte from the head address.
// - After a single read, chip enable may drop or a new command follow.
// - Format 4h burst read outputs bytes, incrementing address with wrap.
// - Burst read ends only when chip enable falls.
// - Single reads and writes chain freely, followed by any format.
// - Format codes 1000, 0000, 1100, 0100 decode write, burst write, read, burst read.
// - Carries held off while chip enable high, released on its fall.
// - Carry may be held at most one second; host keeps frames shorter.
// - With oscillator-halt flag set, the 32.768 kHz clock drives the sub-clock pin.
module rtw_port
(
   // System side
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic carry_tick,
   output logic carry_release,
   output logic carry_hold,
   // Oscillator and sub-clock
   input wire logic osc_32k,
   input wire logic osc_halt_flag,
   output logic sub_clock_output,
   // Three-wire link
   input wire logic chip_en,
   input wire logic sclk,
   input wire logic shared_serial_line_in,
   output logic shared_serial_line_out,
   output logic shared_serial_line_oe
);

   // Format decoding, shared by the state register and the address pointer
   function automatic logic fmt_is_burst(input logic [3:0] fmt);
      fmt_is_burst = (fmt == `RTW_FMT_WR_BURST) || (fmt == `RTW_FMT_RD_BURST);
   endfunction : fmt_is_burst

   // Unknown codes leave the port waiting for a new command byte
   function automatic rtw_pkg::rtw_state_type fmt_to_state(input logic [3:0] fmt);
      case (fmt)
         `RTW_FMT_WR_ONE: fmt_to_state = rtw_pkg::RTW_ST_WR;
         `RTW_FMT_WR_BURST: fmt_to_state = rtw_pkg::RTW_ST_WR;
         `RTW_FMT_RD_ONE: fmt_to_state = rtw_pkg::RTW_ST_RD;
         `RTW_FMT_RD_BURST: fmt_to_state = rtw_pkg::RTW_ST_RD;
         default: fmt_to_state = rtw_pkg::RTW_ST_CMD;
      endcase
   endfunction : fmt_to_state

   // First bit of each byte, as seen by the drive edge
   function automatic logic at_byte_start(input logic [2:0] cnt);
      at_byte_start = (cnt == `RTW_RST_CNT);
   endfunction : at_byte_start

   // Pointer step; four bits wrap from the top address back to zero
   function automatic logic [`RTW_ADDR_W-1:0] addr_step(input logic [`RTW_ADDR_W-1:0] addr);
      addr_step = addr + `RTW_ADDR_STEP;
   endfunction : addr_step

   // ---------------- Link domain ----------------
   // Flip-flops here run on edges of the host clock; all but the byte store clear while chip enable is low
   // Frame control
   logic edge_mode_reg;
   logic frame_rst_b;
   logic sample_clk;
   rtw_pkg::rtw_state_type state_reg;
   logic [2:0] bit_cnt_reg;
   logic [`RTW_ADDR_W-1:0] addr_reg;
   logic [3:0] fmt_reg;
   logic byte_done;
   logic cmd_done;
   logic data_done;
   // Data path
   logic [`RTW_BYTE_W-1:0] shift_reg;
   logic [`RTW_BYTE_W-1:0] byte_in;
   logic [`RTW_BYTE_W-1:0] mem [0:`RTW_NUM_ADDR-1];
   logic [`RTW_BYTE_W-1:0] rd_byte;
   logic [`RTW_BYTE_W-1:0] rd_shift_reg;

   // Clock level follows the pin while chip enable is low and is frozen by its rise.
   // A flip-flop on the chip-enable edge would change the mode in the very instant
   // that the frame opens and could fake a sample edge; this latch never changes there.
   always_latch
   begin
      if (!chip_en)
         edge_mode_reg <= sclk;
   end

   // Idle level of sample_clk is high in both modes, so no edge appears at frame start
   // Low level: sample on falling clock; high level: sample on rising clock
   assign sample_clk = sclk ^ ~edge_mode_reg;
   // Chip enable low also clears the frame, so a cut byte is dropped
   assign frame_rst_b = rst_b & chip_en;

   assign byte_in = {shift_reg[`RTW_BYTE_W-2:0], shared_serial_line_in};
   // Byte boundaries, seen on the sample edge that takes the eighth bit
   assign byte_done = (bit_cnt_reg == `RTW_LAST_BIT);
   assign cmd_done = byte_done && (state_reg == rtw_pkg::RTW_ST_CMD);
   assign data_done = byte_done && (state_reg != rtw_pkg::RTW_ST_CMD);
   assign rd_byte = mem[addr_reg];

   // Bit counter, wraps after every eighth sample
   always_ff @(posedge sample_clk or negedge frame_rst_b)
   begin
      if (!frame_rst_b)
      begin
         bit_cnt_reg <= `RTW_RST_CNT;
      end
      else
      begin
         bit_cnt_reg <= bit_cnt_reg + `RTW_BIT_STEP;
      end
   end

   // Serial-in shift register, most significant bit first
   always_ff @(posedge sample_clk or negedge frame_rst_b)
   begin
      if (!frame_rst_b)
      begin
         shift_reg <= `RTW_RST_BYTE;
      end
      else
      begin
         shift_reg <= byte_in;
      end
   end

   // Transfer state: command byte, then data bytes until a single format ends
   always_ff @(posedge sample_clk or negedge frame_rst_b)
   begin
      if (!frame_rst_b)
         state_reg <= rtw_pkg::RTW_ST_CMD;
      else if (byte_done)
      begin
         case (state_reg)
            rtw_pkg::RTW_ST_CMD:
               state_reg <= fmt_to_state(byte_in[`RTW_FMT_MSB:`RTW_FMT_LSB]);
            rtw_pkg::RTW_ST_WR, rtw_pkg::RTW_ST_RD:
            begin
               if (!fmt_is_burst(fmt_reg))
                  state_reg <= rtw_pkg::RTW_ST_CMD;
            end
            default:
               state_reg <= rtw_pkg::RTW_ST_CMD;
         endcase
      end
   end

   // Address pointer: head address from the command, then steps in bursts
   always_ff @(posedge sample_clk or negedge frame_rst_b)
   begin
      if (!frame_rst_b)
         addr_reg <= `RTW_RST_ADDR;
      else if (cmd_done)
         addr_reg <= byte_in[`RTW_ADDR_MSB:`RTW_ADDR_LSB];
      else if (data_done && fmt_is_burst(fmt_reg))
         addr_reg <= addr_step(addr_reg);
   end

   // Transfer format, kept for the whole command
   always_ff @(posedge sample_clk or negedge frame_rst_b)
   begin
      if (!frame_rst_b)
         fmt_reg <= `RTW_RST_FMT;
      else if (cmd_done)
         fmt_reg <= byte_in[`RTW_FMT_MSB:`RTW_FMT_LSB];
   end

   // Byte store; no reset, so contents are unknown until written and survive chip-enable low
   always_ff @(posedge sample_clk)
   begin
      if (frame_rst_b && data_done && state_reg == rtw_pkg::RTW_ST_WR)
         mem[addr_reg] <= byte_in;
   end

   // Read byte copied at its first bit, then shifted on each drive edge
   always_ff @(negedge sample_clk or negedge frame_rst_b)
   begin
      if (!frame_rst_b)
         rd_shift_reg <= `RTW_RST_BYTE;
      else if (at_byte_start(bit_cnt_reg))
         rd_shift_reg <= rd_byte;
      else
         rd_shift_reg <= {rd_shift_reg[`RTW_BYTE_W-2:0], 1'b0};
   end

   // Read data launched on the drive edge, half a clock ahead of the host sample
   always_ff @(negedge sample_clk or negedge frame_rst_b)
   begin
      if (!frame_rst_b)
         shared_serial_line_out <= 1'b0;
      else if (at_byte_start(bit_cnt_reg))
         shared_serial_line_out <= rd_byte[`RTW_BYTE_W-1];
      else
         shared_serial_line_out <= rd_shift_reg[`RTW_BYTE_W-2];
   end

   // Line is driven only for read-data bytes; a single read lets go after its last bit
   always_ff @(negedge sample_clk or negedge frame_rst_b)
   begin
      if (!frame_rst_b)
         shared_serial_line_oe <= 1'b0;
      else
         shared_serial_line_oe <= (state_reg == rtw_pkg::RTW_ST_RD);
   end

   // ---------------- System domain ----------------
   // Pins reach this domain only through the two-stage synchronisers below
   logic [`RTW_SYNC_N-1:0] async_in;
   logic [`RTW_SYNC_N-1:0] sync_out;
   logic ce_sync;
   logic osc_sync;
   logic halt_sync;
   logic ce_prev_reg;
   logic carry_pend_reg;
   logic ce_fall;

   // Synchroniser inputs, one per pin
   assign async_in = {osc_halt_flag, osc_32k, chip_en};

   generate
      for (genvar gi = 0; gi < `RTW_SYNC_N; gi++)
      begin : g_sync
         rtw_sync2 SYNC
         (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .async_in(async_in[gi]),
            .sync_out(sync_out[gi])
         );
      end
   endgenerate

   assign {halt_sync, osc_sync, ce_sync} = sync_out;

   // Previous synced level; reset matches the idle low pin, so no false fall follows reset
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ce_prev_reg <= 1'b0;
      end
      else
      begin
         ce_prev_reg <= ce_sync;
      end
   end

   assign ce_fall = ce_prev_reg & ~ce_sync;

   // Hold lags the pin by the synchroniser; a tick in those cycles is released at once
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         carry_hold <= 1'b0;
      end
      else
      begin
         carry_hold <= ce_sync;
      end
   end

   // Pending carry: a tick in the same cycle as the release is merged into that release, not kept
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         carry_pend_reg <= 1'b0;
      else if (carry_tick && ce_sync)
         carry_pend_reg <= 1'b1;
      else if (ce_fall)
         carry_pend_reg <= 1'b0;
   end

   // Held ticks merge into one release; a frame must stay under one second
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         carry_release <= 1'b0;
      end
      else
      begin
         carry_release <= (carry_tick && !ce_sync) || (ce_fall && carry_pend_reg);
      end
   end

   // Oscillator level is sampled by the system clock and gated by the halt flag
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sub_clock_output <= 1'b0;
      end
      else
      begin
         sub_clock_output <= osc_sync & halt_sync;
      end
   end

endmodule : rtw_port

// Two-stage synchroniser; only the second stage is read by other logic
module rtw_sync2
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Level in and out
   input wire logic async_in,
   output logic sync_out
);

   logic meta_reg;

   // First stage may go metastable; nothing but the second stage reads it
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         meta_reg <= 1'b0;
      else
         meta_reg <= async_in;
   end

   // Second stage, the settled copy
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         sync_out <= 1'b0;
      else
         sync_out <= meta_reg;
   end

endmodule : rtw_sync2

// [test/rtw_port_chk.sv]
`timescale 1ns/100ps
module rtw_port_chk
(
   // Watched ports
   input wire logic clk_sys, rst_b, carry_tick, carry_release, carry_hold,
   input wire logic osc_32k, osc_halt_flag, sub_clock_output, chip_en, shared_serial_line_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_open; chip_en [*5]; endsequence
   sequence s_shut; !chip_en [*5]; endsequence
   property p_oe; !chip_en |-> !shared_serial_line_oe; endproperty
   a_oe: assert property (p_oe) else $error("line driven idle");
   property p_hold; s_open |-> carry_hold; endproperty
   a_hold: assert property (p_hold) else $error("no hold");
   property p_idle; s_shut |-> !carry_hold; endproperty
   a_idle: assert property (p_idle) else $error("stuck hold");
   property p_free; s_shut ##0 carry_tick |=> carry_release; endproperty
   a_free: assert property (p_free) else $error("carry kept");
   property p_kept; s_open ##0 carry_tick |=> !carry_release; endproperty
   a_kept: assert property (p_kept) else $error("carry leaked");
   property p_late; s_open ##0 carry_tick ##1 chip_en [*3] ##1 !chip_en |-> ##[1:6] carry_release; endproperty
   a_late: assert property (p_late) else $error("carry lost");
   property p_sub; (osc_32k && osc_halt_flag) [*5] |-> sub_clock_output; endproperty
   a_sub: assert property (p_sub) else $error("sub clock low");
   property p_mute; !osc_halt_flag [*5] |-> !sub_clock_output; endproperty
   a_mute: assert property (p_mute) else $error("sub clock on");
endmodule : rtw_port_chk

bind rtw_port rtw_port_chk CHK (.*);

// [test/rtw_host.sv]
`timescale 1ns/100ps
module rtw_host
(
   // Device side
   input wire logic shared_serial_line_out, shared_serial_line_oe,
   // Host side
   output logic chip_en = 1'b0, sclk = 1'b0,
   output wire shared_serial_line_in
);
   logic pol = 1'b0, dat = 1'b0;
   assign shared_serial_line_in = shared_serial_line_oe ? shared_serial_line_out : dat;
   task open(input logic p);
      pol = p;
      sclk = p;
      #100 chip_en = 1'b1;
      #31000;
   endtask : open
   task shut;
      #300 chip_en = 1'b0;
      #61000;
   endtask : shut
   task xfer(input logic [7:0] tx, output logic [7:0] rx, en);
      for (int i = 7; i >= 0; i--)
      begin
         sclk = ~pol;
         dat = tx[i];
         #31 rx[i] = shared_serial_line_in;
         en[i] = shared_serial_line_oe;
         #1 sclk = pol;
         #32;
      end
   endtask : xfer
endmodule : rtw_host

// [test/test_rtw_port.sv]
`timescale 1ns/100ps
module test_rtw_port;
   logic clk_sys = 1'b0, rst_b = 1'b0, carry_tick = 1'b0, osc_32k = 1'b0, osc_halt_flag = 1'b0;
   logic carry_release, carry_hold, sub_clock_output, shared_serial_line_out, shared_serial_line_oe, chip_en, sclk;
   wire shared_serial_line_in;
   logic [7:0] rx, en, rels = 8'h00;
   int miscompares = 0, checked = 0;
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) rels <= rels + {7'h0, carry_release === 1'b1};
   rtw_port DUT (.*);
   rtw_host HOST (.*);
   task chk(input string n, input logic [7:0] e, g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task conclude;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude
   // Bit 8 marks a read whose expected byte is in bits 7:0
   task run(input logic p, input logic [8:0] s[$]);
      HOST.open(p);
      foreach (s[i])
      begin
         HOST.xfer(s[i][8] ? 8'h55 : s[i][7:0], rx, en);
         if (s[i][8])
            chk("read byte", s[i][7:0], rx);
         chk("line enable", {8{s[i][8]}}, en);
      end
      HOST.shut;
   endtask : run
   task tick;
      @(negedge clk_sys) carry_tick = 1'b1;
      @(negedge clk_sys) carry_tick = 1'b0;
   endtask : tick
   task t_sub;
      {osc_32k, osc_halt_flag} = 2'h3;
      repeat (6) @(negedge clk_sys);
      chk("sub clock", 8'h01, {7'h0, sub_clock_output});
      osc_halt_flag = 1'b0;
      repeat (6) @(negedge clk_sys);
      chk("sub clock", 8'h00, {7'h0, sub_clock_output});
      $display("sub clock done");
   endtask : t_sub
   task t_carry;
      tick;
      HOST.open(1'b0);
      tick;
      tick;
      chk("carries", 8'h01, rels);
      HOST.shut;
      chk("carries", 8'h02, rels);
      $display("carry done");
   endtask : t_carry
   task t_single;
      run(1'b0, '{9'h0f8, 9'h0a5, 9'h0fc, 9'h1a5, 9'h038, 9'h03c, 9'h03c, 9'h13c});
      $display("single done");
   endtask : t_single
   task t_burst;
      run(1'b0, '{9'h0e0, 9'h011, 9'h022, 9'h033, 9'h044});
      run(1'b1, '{9'h052, 9'h0f4, 9'h122, 9'h133, 9'h144});
      $display("burst done");
   endtask : t_burst
   initial
   begin
      repeat (10) @(negedge clk_sys);
      rst_b = 1'b1;
      t_sub;
      t_carry;
      t_single;
      t_burst;
      conclude;
   end
endmodule : test_rtw_port
